// [core/master_clock_controller.sv]
`timescale 1ns/1ps
`include "mcc_defines.svh"

// Functional notes
// - Four master sources are selectable: external crystal, user external clock, RC and low RC.
// - After reset the master clock is the internal RC divided by eight.
// - A newly requested source takes over only once it reports ready.
// - A changeover requested by software happens on a master tick boundary so no period is ever shortened.
// - Core and peripheral ticks pass through a programmable power-of-two prescaler.
// - The core, the memory and each peripheral have a tick gate of their own.
// - With the monitor enabled, a failed external source forces the RC divided by eight.
// - Peripheral gates sit in two registers at fixed bits, other bits reserved.
// - A selectable tick (master, RC, low RC or crystal) drives the clock output pin.
module master_clock_controller #(
  parameter int MON_TIMEOUT_CYCLES = `MON_TIMEOUT_CYCLES
) (
  input  wire logic                 I_REF_CLK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_HSEL,
  input  wire logic [31:0]          I_HADDR,
  input  wire logic [1:0]           I_HTRANS,
  input  wire logic                 I_HWRITE,
  input  wire logic [2:0]           I_HSIZE,
  input  wire logic [31:0]          I_HWDATA,
  input  wire logic                 I_HREADY,
  input  wire logic [3:0]           I_SRC_TICK,
  input  wire logic [3:0]           I_SRC_READY,
  output logic [31:0]               O_HRDATA,
  output logic                      O_HREADYOUT,
  output logic                      O_HRESP,
  output logic                      O_MASTER_TICK,
  output mcc_pkg::gated_ticks_s     O_GATED_TICK,
  output logic                      O_CLK_OUT,
  output logic                      O_MON_IRQ
);
  import mcc_pkg::*;

  if (MON_TIMEOUT_CYCLES < 2 || MON_TIMEOUT_CYCLES > 255) begin : g_bad_timeout
    $error("master_clock_controller: MON_TIMEOUT_CYCLES must be 2 to 255.");
  end

  localparam logic [7:0] TIMEOUT = 8'(MON_TIMEOUT_CYCLES);

  // ****************************************************************
  // Register state
  // ****************************************************************
  source_e     cur_src_reg;
  source_e     req_src_reg;
  sw_state_e   sw_state_reg;
  logic [2:0]  ratio_reg;
  logic [7:0]  gate_one_reg;
  logic [7:0]  gate_two_reg;
  logic [1:0]  core_gate_reg;
  logic        mon_en_reg;
  logic        mon_ie_reg;
  logic        mon_flag_reg;
  logic [7:0]  mon_cnt_reg;
  logic        out_en_reg;
  logic [1:0]  out_sel_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        master_tick;
  logic        sel_tick;
  logic        wr_switch;
  logic        monitoring;
  logic        mon_fail;
  logic        switch_now;
  logic        out_tick;
  logic [31:0] rd_mux;
  logic        addr_ok;
  logic        req_ready;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  assign addr_ok = I_HSEL && I_HREADY && I_HTRANS[1] && (I_HADDR[31:8] == 24'h000000)
                   && (I_HADDR[1:0] == 2'h0);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      O_HRDATA    <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok && I_HWRITE && (I_HSIZE == 3'h2);
      rd_pend_reg <= addr_ok && !I_HWRITE;
      if (addr_ok) begin
        addr_reg <= I_HADDR[7:0];
      end
      // Reads insert one wait state so the data always come from a register.
      if (addr_ok && !I_HWRITE) begin
        O_HREADYOUT <= 1'b0;
      end else if (rd_pend_reg) begin
        O_HREADYOUT <= 1'b1;
        O_HRDATA    <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_reg == `OFS_SWITCH) begin
      rd_mux[`SW_REQ_LSB +: 2] = req_src_reg;
      rd_mux[`SW_CUR_LSB +: 2] = cur_src_reg;
      rd_mux[`SW_BUSY_BIT]     = (sw_state_reg != SW_IDLE);
    end else if (addr_reg == `OFS_PRESCALE) begin
      rd_mux[2:0] = ratio_reg;
    end else if (addr_reg == `OFS_GATE_ONE) begin
      rd_mux[7:0] = gate_one_reg;
    end else if (addr_reg == `OFS_GATE_TWO) begin
      rd_mux[7:0] = gate_two_reg;
    end else if (addr_reg == `OFS_CORE_GATE) begin
      rd_mux[1:0] = core_gate_reg;
    end else if (addr_reg == `OFS_SECURITY) begin
      rd_mux[`SEC_EN_BIT]   = mon_en_reg;
      rd_mux[`SEC_IE_BIT]   = mon_ie_reg;
      rd_mux[`SEC_FLAG_BIT] = mon_flag_reg;
    end else if (addr_reg == `OFS_CLKOUT) begin
      rd_mux[`OUT_EN_BIT]       = out_en_reg;
      rd_mux[`OUT_SEL_LSB +: 2] = out_sel_reg;
    end
  end

  // ****************************************************************
  // Source selection and glitch-free switch
  // ****************************************************************
  assign sel_tick   = I_SRC_TICK[cur_src_reg];
  assign wr_switch  = wr_pend_reg && (addr_reg == `OFS_SWITCH);
  assign req_ready  = I_SRC_READY[req_src_reg];
  assign switch_now = (sw_state_reg == SW_ALIGN) && !wr_switch && req_ready
                      && master_tick;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      cur_src_reg  <= SRC_FAST_RC;
      req_src_reg  <= SRC_FAST_RC;
      sw_state_reg <= SW_IDLE;
    end else if (mon_fail) begin
      cur_src_reg  <= SRC_FAST_RC;
      req_src_reg  <= SRC_FAST_RC;
      sw_state_reg <= SW_IDLE;
    end else begin
      if (wr_switch) begin
        req_src_reg <= source_e'(I_HWDATA[`SW_REQ_LSB +: 2]);
      end
      case (sw_state_reg)
        SW_IDLE: begin
          if (wr_switch && (I_HWDATA[`SW_REQ_LSB +: 2] != cur_src_reg)) begin
            sw_state_reg <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (req_src_reg == cur_src_reg) begin
            sw_state_reg <= SW_IDLE;
          end else if (!wr_switch && req_ready) begin
            sw_state_reg <= SW_ALIGN;
          end
        end
        SW_ALIGN: begin
          if (wr_switch || !req_ready) begin
            sw_state_reg <= SW_WAIT;
          end else if (master_tick) begin
            cur_src_reg  <= req_src_reg;
            sw_state_reg <= SW_IDLE;
          end
        end
        default: begin
          sw_state_reg <= SW_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ratio_reg <= `PRE_RESET;
    end else if (mon_fail) begin
      ratio_reg <= `PRE_RESET;
    end else if (wr_pend_reg && (addr_reg == `OFS_PRESCALE)) begin
      ratio_reg <= I_HWDATA[2:0];
    end
  end

  // The divider phase restarts on a changeover so the first new period is whole.
  clk_prescaler #(
    .RATIO_W (3)
  ) u_prescaler (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (I_RST_N),
    .i_tick    (sel_tick),
    .i_restart (switch_now || mon_fail),
    .i_ratio   (ratio_reg),
    .o_tick    (master_tick)
  );

  assign O_MASTER_TICK = master_tick;

  // ****************************************************************
  // Clock gates
  // ****************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      gate_one_reg  <= `GATE_ONE_RESET;
      gate_two_reg  <= `GATE_TWO_RESET;
      core_gate_reg <= `CORE_RESET;
    end else if (wr_pend_reg) begin
      if (addr_reg == `OFS_GATE_ONE) begin
        gate_one_reg <= I_HWDATA[7:0] & `GATE_ONE_MASK;
      end else if (addr_reg == `OFS_GATE_TWO) begin
        gate_two_reg <= I_HWDATA[7:0] & `GATE_TWO_MASK;
      end else if (addr_reg == `OFS_CORE_GATE) begin
        core_gate_reg <= I_HWDATA[1:0];
      end
    end
  end

  clk_gate_bank #(
    .N (10)
  ) u_gates (
    .i_clk    (I_REF_CLK),
    .i_rst_n  (I_RST_N),
    .i_tick   (master_tick),
    .i_enable ({core_gate_reg, gate_one_reg[7:6], gate_one_reg[4:3],
                gate_one_reg[1:0], gate_two_reg[3:2]}),
    .o_tick   (O_GATED_TICK)
  );

  // ****************************************************************
  // Security monitor
  // ****************************************************************
  assign monitoring = mon_en_reg && ((cur_src_reg == SRC_XTAL) || (cur_src_reg == SRC_USER));
  assign mon_fail   = monitoring && !sel_tick && (mon_cnt_reg == TIMEOUT - 8'h01);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      mon_cnt_reg <= 8'h00;
    end else if (!monitoring || sel_tick) begin
      mon_cnt_reg <= 8'h00;
    end else if (mon_cnt_reg != TIMEOUT) begin
      mon_cnt_reg <= mon_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      mon_en_reg <= 1'b0;
      mon_ie_reg <= 1'b0;
    end else if (wr_pend_reg && (addr_reg == `OFS_SECURITY)) begin
      mon_en_reg <= I_HWDATA[`SEC_EN_BIT];
      mon_ie_reg <= I_HWDATA[`SEC_IE_BIT];
    end
  end

  // A failure in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      mon_flag_reg <= 1'b0;
    end else if (mon_fail) begin
      mon_flag_reg <= 1'b1;
    end else if (wr_pend_reg && (addr_reg == `OFS_SECURITY) && I_HWDATA[`SEC_FLAG_BIT]) begin
      mon_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_MON_IRQ <= 1'b0;
    end else begin
      O_MON_IRQ <= mon_flag_reg && mon_ie_reg;
    end
  end

  // ****************************************************************
  // Clock output pin
  // ****************************************************************
  always_comb begin
    case (out_sel_reg)
      2'h0:    out_tick = master_tick;
      2'h1:    out_tick = I_SRC_TICK[SRC_FAST_RC];
      2'h2:    out_tick = I_SRC_TICK[SRC_SLOW_RC];
      default: out_tick = I_SRC_TICK[SRC_XTAL];
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      out_en_reg  <= 1'b0;
      out_sel_reg <= 2'h0;
    end else if (wr_pend_reg && (addr_reg == `OFS_CLKOUT)) begin
      out_en_reg  <= I_HWDATA[`OUT_EN_BIT];
      out_sel_reg <= I_HWDATA[`OUT_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_CLK_OUT <= 1'b0;
    end else if (!out_en_reg) begin
      O_CLK_OUT <= 1'b0;
    end else if (out_tick) begin
      O_CLK_OUT <= !O_CLK_OUT;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_fail;
    mon_fail;
  endsequence

  sequence s_fallback;
    ##1 (cur_src_reg == SRC_FAST_RC) && (ratio_reg == 3'h3) && mon_flag_reg;
  endsequence

  property p_reset_state;
    $rose(I_RST_N) |-> (cur_src_reg == SRC_FAST_RC) && (ratio_reg == 3'h3);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Master source is not RC divided by eight after reset.");

  property p_hold_until_ready;
    (sw_state_reg == SW_WAIT) && !mon_fail |=> $stable(cur_src_reg);
  endproperty
  a_hold_until_ready: assert property (p_hold_until_ready)
    else $error("Source changed before the new source was ready.");

  property p_switch_boundary;
    $changed(cur_src_reg) |-> $past(master_tick) || $past(mon_fail);
  endproperty
  a_switch_boundary: assert property (p_switch_boundary)
    else $error("Source changed away from a master tick boundary.");

  property p_prescale_gap;
    master_tick && (ratio_reg != 3'h0) |=> !master_tick;
  endproperty
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("Prescaled master ticks came back to back.");

  property p_gate_off;
    !gate_one_reg[7] |=> !O_GATED_TICK.timer_one;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("Gated timer tick passed while its gate was off.");

  property p_fallback;
    s_fail |-> s_fallback;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("Failure did not fall back to RC divided by eight.");

  property p_reserved;
    ((gate_one_reg & ~`GATE_ONE_MASK) == 8'h00) && ((gate_two_reg & ~`GATE_TWO_MASK) == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("A reserved gate bit was set.");

  property p_clk_out;
    out_en_reg && out_tick |=> O_CLK_OUT != $past(O_CLK_OUT);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("Clock output did not toggle on its selected tick.");

  property p_irq;
    mon_fail && mon_ie_reg && !(wr_pend_reg && (addr_reg == `OFS_SECURITY)) |-> ##2 O_MON_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Enabled failure request did not appear two cycles later.");

endmodule : master_clock_controller

// [core/mcc_defines.svh]
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SWITCH     8'h00
`define OFS_PRESCALE   8'h04
`define OFS_GATE_ONE   8'h08
`define OFS_GATE_TWO   8'h0C
`define OFS_CORE_GATE  8'h10
`define OFS_SECURITY   8'h14
`define OFS_CLKOUT     8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define SW_REQ_LSB     0
`define SW_CUR_LSB     4
`define SW_BUSY_BIT    8
`define SEC_EN_BIT     0
`define SEC_IE_BIT     1
`define SEC_FLAG_BIT   2
`define OUT_EN_BIT     0
`define OUT_SEL_LSB    1

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define PRE_RESET      3'h3
`define GATE_ONE_MASK  8'hDB
`define GATE_TWO_MASK  8'h0C
`define GATE_ONE_RESET 8'hDB
`define GATE_TWO_RESET 8'h0C
`define CORE_RESET     2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_MHZ        40
`define MON_TIMEOUT_NS     2000
`define MON_TIMEOUT_CYCLES ((`MON_TIMEOUT_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// [core/mcc_pkg.sv]
package mcc_pkg;

  typedef enum logic [1:0] {
    SRC_FAST_RC = 2'h0,
    SRC_XTAL    = 2'h1,
    SRC_USER    = 2'h2,
    SRC_SLOW_RC = 2'h3
  } source_e;

  typedef enum logic [1:0] {
    SW_IDLE  = 2'h0,
    SW_WAIT  = 2'h1,
    SW_ALIGN = 2'h3
  } sw_state_e;

  typedef struct packed {
    logic core;
    logic memory;
    logic timer_one;
    logic timer_five;
    logic timer_six;
    logic serial_port;
    logic spi;
    logic i2c;
    logic adc;
    logic auto_wakeup;
  } gated_ticks_s;

endpackage : mcc_pkg

// [core/clk_prescaler.sv]
`timescale 1ns/1ps

// ****************************************************************
// Power-of-two tick divider with phase restart
// ****************************************************************
module clk_prescaler #(
  parameter int RATIO_W = 3
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_tick,
  input  wire logic               i_restart,
  input  wire logic [RATIO_W-1:0] i_ratio,
  output logic                    o_tick
);
  localparam int CW = (1 << RATIO_W) - 1;

  if (RATIO_W < 1 || RATIO_W > 4) begin : g_bad_width
    $error("clk_prescaler: RATIO_W must be 1 to 4.");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] lim;

  assign lim = CW'((CW'(1) << i_ratio) - CW'(1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (i_restart) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (i_tick) begin
      if (cnt_reg >= lim) begin
        cnt_reg <= '0;
        o_tick  <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
        o_tick  <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end
endmodule : clk_prescaler

// [core/clk_gate_bank.sv]
`timescale 1ns/1ps

// ****************************************************************
// Bank of registered clock-enable gates
// ****************************************************************
module clk_gate_bank #(
  parameter int N = 10
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_tick,
  input  wire logic [N-1:0] i_enable,
  output logic      [N-1:0] o_tick
);
  if (N < 1) begin : g_bad_n
    $error("clk_gate_bank: N must be at least 1.");
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tick <= '0;
    end else begin
      o_tick <= {N{i_tick}} & i_enable;
    end
  end
endmodule : clk_gate_bank

// [dv/src_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// Oscillator sources
// ****************************************************************
module src_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_stop,
  input  wire logic [3:0] i_ready,
  output logic      [3:0] o_tick,
  output logic      [3:0] o_ready
);
  // Tick spacing of RC, crystal, user clock and low RC, in reference cycles.
  localparam logic [3:0] PER [4] = '{4'h2, 4'h3, 4'h4, 4'h8};
  logic [3:0] cnt_reg [4];

  // A stopped source gives no tick at all, as a failed oscillator would.
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!i_rst_n || cnt_reg[k] == PER[k] - 4'h1) cnt_reg[k] <= 4'h0;
      else cnt_reg[k] <= cnt_reg[k] + 4'h1;
      o_tick[k] <= i_rst_n && !i_stop[k] && (cnt_reg[k] == 4'h0);
    end
  end

  assign o_ready = i_ready;
endmodule : src_model

// [dv/master_clock_controller_tb.sv]
`timescale 1ns/1ps
`include "mcc_defines.svh"

module master_clock_controller_tb;
  import mcc_pkg::*;
  logic         clk;
  logic         rst_n;
  logic [1:0]   htrans;
  logic [31:0]  haddr;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic [3:0]   stop;
  logic [3:0]   rdy_en;
  logic [3:0]   tick;
  logic [3:0]   ready;
  logic         mtick;
  gated_ticks_s gated;
  logic         clk_out;
  logic         irq;
  int           mismatches;
  int           cmp_count;
  logic [31:0]  rd;

  master_clock_controller #(.MON_TIMEOUT_CYCLES(8)) master_clock_controller_i (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hready), .I_SRC_TICK(tick), .I_SRC_READY(ready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .O_MASTER_TICK(mtick),
    .O_GATED_TICK(gated), .O_CLK_OUT(clk_out), .O_MON_IRQ(irq));

  src_model src_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_stop(stop),
    .i_ready(rdy_en), .o_tick(tick), .o_ready(ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // Waits for hready at a rising edge; values seen are those before the edge.
  task automatic wait_ready();
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // Returns the spacing in cycles of two master ticks.
  task automatic period(output int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (mtick !== 1'b1 && n < 200);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (mtick !== 1'b1 && p < 200);
  endtask : period

  task automatic count(input int cyc, output int n_core, output int n_t1, output int n_co);
    logic last;
    n_core = 0;
    n_t1   = 0;
    n_co   = 0;
    // One edge first, so that a register written just before is in force for the whole window.
    @(posedge clk);
    last   = clk_out;
    repeat (cyc) begin
      @(posedge clk);
      n_core += (gated.core === 1'b1);
      n_t1   += (gated.timer_one === 1'b1);
      n_co   += (clk_out !== last);
      last    = clk_out;
    end
  endtask : count

  task automatic switch_to(input logic [1:0] s);
    int n;
    ahb(1'b1, `OFS_SWITCH, {30'h0, s});
    n = 0;
    do begin
      ahb(1'b0, `OFS_SWITCH, 32'h0);
      n++;
    end while (rd[`SW_BUSY_BIT] === 1'b1 && n < 30);
    check(rd, {26'h0, s, 2'h0, s});
  endtask : switch_to

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    int p;
    rd_chk(`OFS_SWITCH, 32'h0);
    rd_chk(`OFS_PRESCALE, 32'h3);
    rd_chk(`OFS_GATE_ONE, 32'hDB);
    rd_chk(`OFS_GATE_TWO, 32'h0C);
    rd_chk(`OFS_CORE_GATE, 32'h3);
    rd_chk(`OFS_SECURITY, 32'h0);
    rd_chk(`OFS_CLKOUT, 32'h0);
    rd_chk(32'h1C, 32'h0);
    period(p);
    check(p, 32'd16);
    check(hresp, 1'b0);
  endtask : t_reset

  task automatic t_gates();
    int c;
    int t;
    int o;
    ahb(1'b1, `OFS_PRESCALE, 32'h1);
    period(c);
    check(c, 32'd4);
    ahb(1'b1, `OFS_GATE_ONE, 32'hFF);
    rd_chk(`OFS_GATE_ONE, 32'hDB);
    ahb(1'b1, `OFS_GATE_TWO, 32'hFF);
    rd_chk(`OFS_GATE_TWO, 32'h0C);
    count(40, c, t, o);
    check(t, 32'd10);
    ahb(1'b1, `OFS_GATE_ONE, 32'h7F);
    ahb(1'b1, `OFS_CORE_GATE, 32'h1);
    count(40, c, t, o);
    check({c[15:0], t[15:0]}, 32'h0);
    ahb(1'b1, `OFS_CORE_GATE, 32'h3);
  endtask : t_gates

  task automatic t_switch();
    int p;
    ahb(1'b1, `OFS_SWITCH, 32'h1);
    repeat (30) @(posedge clk);
    rd_chk(`OFS_SWITCH, 32'h101);
    rdy_en <= 4'hF;
    switch_to(2'h1);
    ahb(1'b1, `OFS_PRESCALE, 32'h0);
    period(p);
    check(p, 32'd3);
    switch_to(2'h2);
    period(p);
    check(p, 32'd4);
    switch_to(2'h3);
    period(p);
    check(p, 32'd8);
    switch_to(2'h1);
  endtask : t_switch

  task automatic t_monitor();
    int p;
    ahb(1'b1, `OFS_SECURITY, 32'h3);
    stop <= 4'h2;
    repeat (20) @(posedge clk);
    rd_chk(`OFS_SWITCH, 32'h0);
    rd_chk(`OFS_PRESCALE, 32'h3);
    rd_chk(`OFS_SECURITY, 32'h7);
    check(irq, 1'b1);
    period(p);
    check(p, 32'd16);
    stop <= 4'h0;
    ahb(1'b1, `OFS_SECURITY, 32'h1);
    rd_chk(`OFS_SECURITY, 32'h5);
    check(irq, 1'b0);
    ahb(1'b1, `OFS_SECURITY, 32'h5);
    repeat (20) @(posedge clk);
    rd_chk(`OFS_SECURITY, 32'h1);
    check(irq, 1'b0);
    ahb(1'b1, `OFS_SECURITY, 32'h0);
  endtask : t_monitor

  task automatic t_clkout();
    int c;
    int t;
    int o;
    ahb(1'b1, `OFS_CLKOUT, 32'h3);
    count(40, c, t, o);
    check(o, 32'd20);
    ahb(1'b1, `OFS_CLKOUT, 32'h5);
    count(40, c, t, o);
    check(o, 32'd5);
    ahb(1'b1, `OFS_CLKOUT, 32'h1);
    count(48, c, t, o);
    check(o, 32'd3);
    ahb(1'b1, `OFS_CLKOUT, 32'h7);
    count(48, c, t, o);
    check(o, 32'd16);
    ahb(1'b1, `OFS_CLKOUT, 32'h4);
    @(posedge clk);
    count(10, c, t, o);
    check({o[30:0], clk_out}, 32'h0);
  endtask : t_clkout

  initial begin
    mismatches = 0;
    cmp_count  = 0;
    rst_n  = 1'b0;
    htrans = 2'h0;
    haddr  = 32'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    stop   = 4'h0;
    rdy_en = 4'hD;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_gates();
    t_switch();
    t_monitor();
    t_clkout();
    report_and_stop();
  end

  initial begin
    #(25 * 20000);
    mismatches++;
    report_and_stop();
  end
endmodule : master_clock_controller_tb
